// [adc_link_checker.sv]
// Purpose: Assertions on the link between host and converter power control.
// Assumes: One clock pclk; presetn is active low.
// Notes: The device samples link pins through two flip-flops, so its reactions lag the pins.
module adc_link_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic conversion_select_line,
  input wire logic ready_indicator,
  input wire adc_power_pkg::dev_state_t state,
  input wire logic doze_state,
  input wire logic deep_sleep_state,
  input wire logic analog_powered,
  input wire logic acq_low_power,
  input wire logic doze_enable,
  input wire logic deep_sleep_request,
  input wire logic unlocked
);
  timeunit 1ns;
  timeprecision 1ns;
  import adc_power_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_unlock_gate;
    ($past(doze_enable) != doze_enable) || ($past(deep_sleep_request) != deep_sleep_request) |-> $past(unlocked);
  endproperty
  a_unlock_gate: assert property (p_unlock_gate) else $error("power bits changed without unlock");
  property p_doze_entry;
    $rose(doze_state) |-> $past(doze_enable) && $past(conversion_select_line, 3);
  endproperty
  a_doze_entry: assert property (p_doze_entry) else $error("doze entered without enable and select high");
  property p_doze_hold;
    doze_state && conversion_select_line |=> doze_state;
  endproperty
  a_doze_hold: assert property (p_doze_hold) else $error("doze left while select high");
  property p_doze_power;
    acq_low_power == doze_state;
  endproperty
  a_doze_power: assert property (p_doze_power) else $error("low power flag disagrees with doze");
  property p_doze_exit;
    $fell(conversion_select_line) && doze_state |-> ##[1:4] !doze_state;
  endproperty
  a_doze_exit: assert property (p_doze_exit) else $error("doze not left after select fall");
  property p_wake_gap;
    $fell(conversion_select_line) |-> !conversion_select_line [*8];
  endproperty
  a_wake_gap: assert property (p_wake_gap) else $error("select raised too soon after fall");
  property p_deep_entry;
    $rose(deep_sleep_state) |-> $past(deep_sleep_request) && conversion_select_line;
  endproperty
  a_deep_entry: assert property (p_deep_entry) else $error("deep sleep entered without request");
  property p_deep_hold;
    deep_sleep_state |-> !analog_powered && ready_indicator;
  endproperty
  a_deep_hold: assert property (p_deep_hold) else $error("deep sleep with analog on or ready low");
  property p_recover;
    deep_sleep_state && !deep_sleep_request |-> ##[1:2] !deep_sleep_state && ready_indicator;
  endproperty
  a_recover: assert property (p_recover) else $error("deep sleep not left after clear");
  property p_normal;
    state == ST_ACQ || state == ST_CONV |-> analog_powered && !acq_low_power;
  endproperty
  a_normal: assert property (p_normal) else $error("normal mode not fully powered");
  c_doze: cover property ($rose(doze_state));
  c_deep: cover property ($rose(deep_sleep_state));
  c_wake: cover property ($fell(deep_sleep_state));
  c_unlock: cover property ($rose(unlocked));
endmodule

// [adc_link_if.sv]
// Purpose: Pins between the converter and its host controller.
// Assumes: Host drives select, serial clock and data; device drives the ready indicator.
// Notes: Select idles high.
interface adc_link_if;
  logic conversion_select_line;
  logic sclk;
  logic sdi;
  logic ready_indicator;
  modport dev (
    input conversion_select_line,
    input sclk,
    input sdi,
    output ready_indicator
  );
  modport host (
    output conversion_select_line,
    output sclk,
    output sdi,
    input ready_indicator
  );
endinterface

// [adc_power_device.sv]
// Purpose: Converter-side power control: doze, deep sleep, unlock and ready indicator.
// Assumes: Link pins are asynchronous to pclk and pass two flip-flops first.
// Notes: A frame is 16 bits, address byte then data byte, MSB first, taken at the select rising edge.
`include "adc_power_map.svh"

// Notes on behaviour
// - Unlock byte 69h at 05h enables power writes.
// - Doze entered at conversion end if enabled.
// - Doze lasts while select stays high.
// - Doze lowers internal power during acquisition.
// - Select falling edge ends doze.
// - Host waits doze wake time before rising.
// - Deep sleep entered at next select rise.
// - Deep sleep: analog off, interface and registers kept.
// - Ready indicator high during deep sleep.
// - Host clears deep-sleep request to leave.
// - Ready indicator high once recovery begins.
// - Host waits recovery time before converting.
// - Normal mode stays fully powered between conversions.
module adc_power_device #(
  parameter int CONV_CYC = `CONV_CYC,
  parameter int DOZE_WAKE_CYC = `DOZE_WAKE_CYC,
  parameter int RECOVER_CYC = `RECOVER_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  adc_link_if.dev lnk,
  output adc_power_pkg::dev_state_t state,
  output logic doze_state,
  output logic deep_sleep_state,
  output logic analog_powered,
  output logic acq_low_power,
  output logic doze_enable,
  output logic deep_sleep_request,
  output logic unlocked,
  output logic conv_done
);
  import adc_power_pkg::*;

  logic [2:0] cs_sync_r;
  logic [2:0] ck_sync_r;
  logic [1:0] di_sync_r;
  logic cs_level;
  logic cs_rise;
  logic cs_fall;
  logic ck_rise;
  logic [4:0] bit_cnt_r;
  logic [15:0] shift_r;
  logic frame_ok;
  logic [7:0] fr_addr;
  logic [7:0] fr_data;
  logic unlock_r;
  logic [7:0] pwr_ctrl_r;
  dev_state_t state_r;
  logic [31:0] cnt_r;
  logic ready_r;
  logic conv_done_r;

  // The edge detectors look at stages two and three only, never at the first stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_sync_r <= 3'h7;
      ck_sync_r <= 3'h0;
      di_sync_r <= 2'h0;
    end else begin
      cs_sync_r <= {cs_sync_r[1:0], lnk.conversion_select_line};
      ck_sync_r <= {ck_sync_r[1:0], lnk.sclk};
      di_sync_r <= {di_sync_r[0], lnk.sdi};
    end
  end

  assign cs_level = cs_sync_r[1];
  assign cs_rise = cs_sync_r[1] & ~cs_sync_r[2];
  assign cs_fall = ~cs_sync_r[1] & cs_sync_r[2];
  assign ck_rise = ck_sync_r[1] & ~ck_sync_r[2];

  // Bits beyond the sixteenth are dropped, so an overlong frame still commits its first 16.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_r <= 5'h00;
      shift_r <= 16'h0000;
    end else if (cs_fall) begin
      bit_cnt_r <= 5'h00;
    end else if (!cs_level && ck_rise && bit_cnt_r != 5'(`FRAME_BITS)) begin
      shift_r <= {shift_r[14:0], di_sync_r[1]};
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  assign frame_ok = cs_rise && (bit_cnt_r == 5'(`FRAME_BITS));
  assign fr_addr = shift_r[15:8];
  assign fr_data = shift_r[7:0];

  // A wrong key or a power write consumes the unlock, so each change needs a fresh key.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_r <= 1'b0;
    end else if (frame_ok && fr_addr == `UNLOCK_ADDR) begin
      unlock_r <= (fr_data == `UNLOCK_KEY);
    end else if (frame_ok && fr_addr == `PWR_CTRL_ADDR) begin
      unlock_r <= 1'b0;
    end
  end

  // The register stays intact in every state, deep sleep included.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_ctrl_r <= `PWR_CTRL_RESET;
    end else if (frame_ok && fr_addr == `PWR_CTRL_ADDR && unlock_r) begin
      pwr_ctrl_r <= fr_data;
    end
  end

  assign doze_enable = pwr_ctrl_r[`PWR_DOZE_BIT];
  assign deep_sleep_request = pwr_ctrl_r[`PWR_DEEP_BIT];

  // The deep-sleep decision reads the register before the same edge's write lands.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_ACQ;
      cnt_r <= 32'h0000_0000;
    end else begin
      case (state_r)
        ST_ACQ: begin
          if (cs_rise && deep_sleep_request) begin
            state_r <= ST_DEEP;
          end else if (cs_rise) begin
            state_r <= ST_CONV;
            cnt_r <= 32'h0000_0000;
          end
        end
        ST_CONV: begin
          cnt_r <= cnt_r + 32'h0000_0001;
          if (cnt_r == 32'(CONV_CYC - 1)) begin
            if (doze_enable && cs_level) begin
              state_r <= ST_DOZE;
            end else begin
              state_r <= ST_ACQ;
            end
          end
        end
        ST_DOZE: begin
          if (cs_fall) begin
            state_r <= ST_WAKE;
            cnt_r <= 32'h0000_0000;
          end else begin
            state_r <= ST_DOZE;
          end
        end
        ST_WAKE: begin
          cnt_r <= cnt_r + 32'h0000_0001;
          if (cnt_r == 32'(DOZE_WAKE_CYC - 1)) begin
            state_r <= ST_ACQ;
          end
        end
        ST_DEEP: begin
          if (!deep_sleep_request) begin
            state_r <= ST_RECOVER;
            cnt_r <= 32'h0000_0000;
          end
        end
        ST_RECOVER: begin
          cnt_r <= cnt_r + 32'h0000_0001;
          if (cnt_r == 32'(RECOVER_CYC - 1)) begin
            state_r <= ST_ACQ;
          end
        end
        default: begin
          state_r <= ST_ACQ;
          cnt_r <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Ready drops only while a conversion runs, so it stays high in deep sleep and recovery.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_r <= 1'b1;
    end else begin
      ready_r <= (state_r != ST_CONV);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_done_r <= 1'b0;
    end else begin
      conv_done_r <= (state_r == ST_CONV) && (cnt_r == 32'(CONV_CYC - 1));
    end
  end

  assign lnk.ready_indicator = ready_r;
  assign state = state_r;
  assign doze_state = (state_r == ST_DOZE);
  assign acq_low_power = (state_r == ST_DOZE);
  assign deep_sleep_state = (state_r == ST_DEEP);
  assign analog_powered = !(state_r == ST_DEEP || state_r == ST_RECOVER);
  assign unlocked = unlock_r;
  assign conv_done = conv_done_r;
endmodule

// [adc_power_host.sv]
// Purpose: Host controller that drives select and serial pins on orders taken over APB.
// Assumes: The device samples the pins through two flip-flops on its own clock.
// Notes: pready is always high; reads and writes complete with no wait state.
`include "adc_power_map.svh"
module adc_power_host #(
  parameter int DOZE_WAKE_CYC = `DOZE_WAKE_CYC,
  parameter int RECOVER_CYC = `RECOVER_CYC,
  parameter int SCLK_HALF_CYC = `SCLK_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  adc_link_if.host lnk
);
  import adc_power_pkg::*;

  host_state_t state_r;
  logic [31:0] cnt_r;
  logic [15:0] tx_r;
  logic [4:0] bits_left_r;
  logic [1:0] frames_left_r;
  logic cs_r;
  logic sclk_r;
  logic [7:0] pwr_val_r;
  logic deep_set_r;
  logic recover_due_r;
  logic [1:0] rd_sync_r;
  logic [31:0] prdata_r;
  logic wr_acc;
  logic go_conv;
  logic go_pwr;

  assign wr_acc = psel && penable && pwrite;
  assign go_conv = wr_acc && paddr == `HOST_CMD_OFS && pwdata[`CMD_CONVERT_BIT] && state_r == H_IDLE;
  assign go_pwr = wr_acc && paddr == `HOST_CMD_OFS && pwdata[`CMD_POWER_BIT] && state_r == H_IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_sync_r <= 2'h0;
    end else begin
      rd_sync_r <= {rd_sync_r[0], lnk.ready_indicator};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_val_r <= 8'h00;
    end else if (wr_acc && paddr == `HOST_PWR_OFS) begin
      pwr_val_r <= pwdata[7:0];
    end
  end

  // Read data is latched in the setup cycle so it is steady through the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `HOST_PWR_OFS: prdata_r <= {24'h000000, pwr_val_r};
        `HOST_STAT_OFS: prdata_r <= {29'h0, deep_set_r, rd_sync_r[1], state_r != H_IDLE};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Every operation drops select and waits the wake time, as the device may be dozing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= H_IDLE;
      cnt_r <= 32'h0000_0000;
      tx_r <= 16'h0000;
      bits_left_r <= 5'h00;
      frames_left_r <= 2'h0;
      cs_r <= 1'b1;
      sclk_r <= 1'b0;
      deep_set_r <= 1'b0;
      recover_due_r <= 1'b0;
    end else begin
      case (state_r)
        H_IDLE: begin
          cnt_r <= 32'h0000_0000;
          if (go_pwr) begin
            tx_r <= {`UNLOCK_ADDR, `UNLOCK_KEY};
            bits_left_r <= 5'(`FRAME_BITS);
            frames_left_r <= 2'h2;
            cs_r <= 1'b0;
            state_r <= H_LOW;
          end else if (go_conv) begin
            bits_left_r <= 5'h00;
            frames_left_r <= 2'h1;
            cs_r <= 1'b0;
            state_r <= H_LOW;
          end
        end
        H_LOW: begin
          cnt_r <= cnt_r + 32'h0000_0001;
          if (cnt_r == 32'(DOZE_WAKE_CYC + `SYNC_GUARD_CYC - 1)) begin
            cnt_r <= 32'h0000_0000;
            state_r <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (bits_left_r == 5'h00) begin
            cs_r <= 1'b1;
            state_r <= H_GUARD;
          end else begin
            cnt_r <= cnt_r + 32'h0000_0001;
            if (cnt_r == 32'(SCLK_HALF_CYC - 1)) begin
              cnt_r <= 32'h0000_0000;
              sclk_r <= !sclk_r;
              if (sclk_r) begin
                tx_r <= {tx_r[14:0], 1'b0};
                bits_left_r <= bits_left_r - 5'h01;
              end
            end
          end
        end
        H_GUARD: begin
          cnt_r <= cnt_r + 32'h0000_0001;
          if (cnt_r == 32'(`SYNC_GUARD_CYC - 1)) begin
            cnt_r <= 32'h0000_0000;
            state_r <= H_WAIT_READY;
          end
        end
        H_WAIT_READY: begin
          if (rd_sync_r[1] && frames_left_r == 2'h2) begin
            // The deep bit is noted as the power frame is loaded, since the shifter is empty once it has gone out.
            deep_set_r <= pwr_val_r[`PWR_DEEP_BIT];
            tx_r <= {`PWR_CTRL_ADDR, pwr_val_r};
            bits_left_r <= 5'(`FRAME_BITS);
            frames_left_r <= 2'h1;
            cs_r <= 1'b0;
            state_r <= H_LOW;
          end else if (rd_sync_r[1]) begin
            frames_left_r <= 2'h0;
            if (bits_left_r == 5'h00 && tx_r == 16'h0000 && recover_due_r) begin
              state_r <= H_RECOVER;
            end else begin
              state_r <= H_IDLE;
            end
            recover_due_r <= 1'b0;
          end
        end
        H_RECOVER: begin
          cnt_r <= cnt_r + 32'h0000_0001;
          if (cnt_r == 32'(RECOVER_CYC - 1)) begin
            state_r <= H_IDLE;
          end
        end
        default: begin
          state_r <= H_IDLE;
        end
      endcase
      if (state_r == H_IDLE && go_pwr && deep_set_r && !pwr_val_r[`PWR_DEEP_BIT]) begin
        recover_due_r <= 1'b1;
      end
    end
  end

  assign lnk.conversion_select_line = cs_r;
  assign lnk.sclk = sclk_r;
  assign lnk.sdi = tx_r[15];
  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
endmodule

// [adc_power_map.svh]
// Purpose: Offsets, field positions, reset values and timing counts for the power-saving link.
// Assumes: pclk runs at 10 MHz.
// Notes: Times are in ns; cycle counts round least times up.
`ifndef ADC_POWER_MAP_SVH
`define ADC_POWER_MAP_SVH
`define CLK_PERIOD_NS 100
`define UNLOCK_ADDR 8'h05
`define UNLOCK_KEY 8'h69
`define PWR_CTRL_ADDR 8'h04
`define PWR_CTRL_RESET 8'h00
`define PWR_DEEP_BIT 0
`define PWR_DOZE_BIT 1
`define FRAME_BITS 16
`define CONV_TIME_NS 1000
`define CONV_CYC ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DOZE_WAKE_NS 2000
`define DOZE_WAKE_CYC ((`DOZE_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_NS 5000000
`define RECOVER_CYC ((`RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCLK_HALF_CYC 4
`define SYNC_GUARD_CYC 4
`define HOST_CMD_OFS 12'h000
`define HOST_PWR_OFS 12'h004
`define HOST_STAT_OFS 12'h008
`define CMD_CONVERT_BIT 0
`define CMD_POWER_BIT 1
`define STAT_BUSY_BIT 0
`define STAT_READY_BIT 1
`define STAT_DEEP_BIT 2
`endif

// [adc_power_pkg.sv]
// Purpose: Types shared by both ends of the power-saving link.
// Assumes: Nothing beyond the map header.
// Notes: State codes are written out.
package adc_power_pkg;
  typedef enum logic [2:0] {
    ST_ACQ = 3'h0,
    ST_CONV = 3'h1,
    ST_DOZE = 3'h2,
    ST_WAKE = 3'h3,
    ST_DEEP = 3'h4,
    ST_RECOVER = 3'h5
  } dev_state_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_LOW = 3'h1,
    H_SHIFT = 3'h2,
    H_GUARD = 3'h3,
    H_WAIT_READY = 3'h4,
    H_RECOVER = 3'h5
  } host_state_t;
endpackage

// [test_adc_low_power_mode_control.sv]
// Purpose: Bench for host and converter joined by the link interface.
// Assumes: APB master with no wait on pready beyond a bounded loop.
// Notes: A second device is driven directly so that a frame without unlock can be sent.
`include "adc_power_map.svh"
module test_adc_low_power_mode_control;
  timeunit 1ns;
  timeprecision 1ns;
  import adc_power_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  dev_state_t state;
  logic doze_state, deep_sleep_state, analog_powered, acq_low_power, doze_enable, deep_sleep_request, unlocked;
  logic doze_enable2, deep_sleep_request2;
  int errors, compares;
  adc_link_if lnk();
  adc_link_if lnk2();
  adc_power_host #(.DOZE_WAKE_CYC(5), .RECOVER_CYC(20)) adc_power_host_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
  adc_power_device #(.DOZE_WAKE_CYC(5), .RECOVER_CYC(20)) adc_power_device_i (.pclk(pclk),
    .presetn(presetn), .lnk(lnk), .state(state), .doze_state(doze_state), .deep_sleep_state(deep_sleep_state),
    .analog_powered(analog_powered), .acq_low_power(acq_low_power), .doze_enable(doze_enable),
    .deep_sleep_request(deep_sleep_request), .unlocked(unlocked), .conv_done());
  adc_power_device adc_power_device_i2 (.pclk(pclk),
    .presetn(presetn), .lnk(lnk2), .state(), .doze_state(), .deep_sleep_state(), .analog_powered(),
    .acq_low_power(), .doze_enable(doze_enable2), .deep_sleep_request(deep_sleep_request2), .unlocked(),
    .conv_done());
  adc_link_checker adc_link_checker_i (.pclk(pclk), .presetn(presetn),
    .conversion_select_line(lnk.conversion_select_line), .ready_indicator(lnk.ready_indicator), .state(state),
    .doze_state(doze_state), .deep_sleep_state(deep_sleep_state), .analog_powered(analog_powered),
    .acq_low_power(acq_low_power), .doze_enable(doze_enable), .deep_sleep_request(deep_sleep_request),
    .unlocked(unlocked));
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  task test_done;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task chk_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask
  task chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 50) begin
        errors++;
        $display("ERROR pready expected 1 seen %b", pready);
        test_done;
      end
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  // Polls busy; a host that never goes idle ends the run through test_done.
  task wait_idle;
    int n;
    n = 0;
    rd = 32'h1;
    while (rd[`STAT_BUSY_BIT] !== 1'b0) begin
      apb(0, `HOST_STAT_OFS, 32'h0);
      n++;
      if (n > 3000) begin
        errors++;
        $display("ERROR busy expected 0 seen %b", rd[0]);
        test_done;
      end
    end
  endtask
  task host_op(input logic [31:0] pwr, input logic [31:0] cmd);
    apb(1, `HOST_PWR_OFS, pwr);
    apb(1, `HOST_CMD_OFS, cmd);
    wait_idle;
  endtask
  task frame2(input logic [15:0] f);
    @(posedge pclk);
    lnk2.conversion_select_line <= 0;
    repeat (12) @(posedge pclk);
    for (int i = 15; i >= 0; i--) begin
      lnk2.sdi <= f[i];
      repeat (4) @(posedge pclk);
      lnk2.sclk <= 1;
      repeat (4) @(posedge pclk);
      lnk2.sclk <= 0;
    end
    lnk2.sdi <= ~f[0];
    repeat (4) @(posedge pclk);
    lnk2.conversion_select_line <= 1;
    repeat (30) @(posedge pclk);
  endtask
  initial begin
    errors = 0;
    compares = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 12'h000;
    pwdata = 32'h0;
    lnk2.conversion_select_line = 1;
    lnk2.sclk = 0;
    lnk2.sdi = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    repeat (4) @(posedge pclk);
    chk_bit("doze_enable", 1'b0, doze_enable);
    apb(0, 12'h00c, 32'h0);
    chk_word("unmapped", 32'h0, rd);
    chk_bit("pslverr", 1'b0, pslverr);
    host_op(32'h0, 32'h1);
    chk_bit("analog_powered", 1'b1, analog_powered);
    chk_bit("doze_state", 1'b0, doze_state);
    frame2({`PWR_CTRL_ADDR, 8'h02});
    chk_bit("doze_enable2", 1'b0, doze_enable2);
    frame2({`UNLOCK_ADDR, `UNLOCK_KEY});
    frame2({`PWR_CTRL_ADDR, 8'h02});
    chk_bit("doze_enable2", 1'b1, doze_enable2);
    host_op(32'h2, 32'h2);
    chk_bit("doze_enable", 1'b1, doze_enable);
    host_op(32'h2, 32'h1);
    repeat (50) @(posedge pclk);
    chk_bit("doze_state", 1'b1, doze_state);
    chk_bit("acq_low_power", 1'b1, acq_low_power);
    host_op(32'h1, 32'h2);
    chk_bit("doze_state", 1'b0, doze_state);
    chk_bit("deep_sleep_state", 1'b0, deep_sleep_state);
    host_op(32'h1, 32'h1);
    chk_bit("deep_sleep_state", 1'b1, deep_sleep_state);
    chk_bit("analog_powered", 1'b0, analog_powered);
    chk_bit("doze_enable", 1'b0, doze_enable);
    chk_word("stat", 32'h6, rd);
    host_op(32'h0, 32'h2);
    repeat (30) @(posedge pclk);
    chk_bit("deep_sleep_state", 1'b0, deep_sleep_state);
    chk_bit("analog_powered", 1'b1, analog_powered);
    apb(0, `HOST_STAT_OFS, 32'h0);
    chk_word("stat", 32'h2, rd);
    test_done;
  end
endmodule
